// ==== common/sxp_pkg.sv ====
package sxp_pkg;

  // ------------------------------------------------------------------
  // Operation and rounding encodings
  // ------------------------------------------------------------------

  // Operation that produced the incoming result.
  typedef enum logic [3:0] {
    op_packed_add             = 4'h0,
    op_scalar_add             = 4'h1,
    op_packed_subtract        = 4'h2,
    op_scalar_subtract        = 4'h3,
    op_packed_multiply        = 4'h4,
    op_scalar_multiply        = 4'h5,
    op_packed_divide          = 4'h6,
    op_scalar_divide          = 4'h7,
    op_packed_square_root     = 4'h8,
    op_scalar_square_root     = 4'h9,
    op_packed_int_to_float    = 4'hA,
    op_scalar_int_to_float    = 4'hB,
    op_packed_float_to_int    = 4'hC,
    op_scalar_float_to_int    = 4'hD,
    op_packed_float_to_int_trunc = 4'hE,
    op_scalar_float_to_int_trunc = 4'hF
  } sxp_op_type;

  // Rounding control.
  typedef enum logic [1:0] {
    rnd_nearest = 2'h0,
    rnd_down    = 2'h1,
    rnd_up      = 2'h2,
    rnd_zero    = 2'h3
  } sxp_rnd_type;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------

  localparam logic [31:0] SXP_OFS_CTRL   = 32'h0000_0000; // Masks and rounding.
  localparam logic [31:0] SXP_OFS_STATUS = 32'h0000_0004; // Sticky events, read clears.
  localparam logic [31:0] SXP_OFS_IMASK  = 32'h0000_0008; // Interrupt enables.
  localparam logic [31:0] SXP_OFS_RESULT = 32'h0000_000C; // Last delivered result.

  localparam int SXP_CTRL_OVF_MASK = 0; // Overflow masked when set.
  localparam int SXP_CTRL_UNF_MASK = 1; // Underflow masked when set.
  localparam int SXP_CTRL_INX_MASK = 2; // Inexact masked when set.
  localparam int SXP_CTRL_RND_LSB  = 3; // Rounding mode, two bits.

  localparam int SXP_ST_OVF  = 0; // Overflow seen.
  localparam int SXP_ST_UNF  = 1; // Underflow seen.
  localparam int SXP_ST_INX  = 2; // Inexact seen.
  localparam int SXP_ST_TRAP = 3; // Unmasked exception seen.

  localparam logic [2:0] SXP_MASK_RST  = 3'h7; // All exceptions masked.
  localparam logic [3:0] SXP_IMASK_RST = 4'h0; // No interrupt enabled.

  // ------------------------------------------------------------------
  // Number format constants
  // ------------------------------------------------------------------

  localparam logic signed [10:0] SXP_EXP_MAX   = 11'sh07F; // Largest normal exponent.
  localparam logic signed [10:0] SXP_EXP_MIN   = 11'sh782; // Smallest normal, -126.
  localparam logic signed [10:0] SXP_BIAS      = 11'sh07F; // Exponent bias.
  localparam logic signed [10:0] SXP_SCALE     = 11'sh0C0; // Trap scaling, 192.
  localparam logic signed [10:0] SXP_DEN_BASE  = 11'sh782; // Denormal shift base, -126.
  localparam logic signed [10:0] SXP_DEN_SHMAX = 11'sh01F; // Largest denormal shift.
  localparam logic [30:0]        SXP_MAG_INF   = 31'h7F80_0000; // Infinity magnitude.
  localparam logic [30:0]        SXP_MAG_MAX   = 31'h7F7F_FFFF; // Largest finite magnitude.

endpackage

// ==== verilog/sxp_rounder.sv ====
`timescale 1ns/10ps
module sxp_rounder
  import sxp_pkg::*;
(
  input  wire logic        sign,    // Sign of the value.
  input  wire sxp_rnd_type mode,    // Rounding mode.
  input  wire logic [23:0] sig,     // Significand kept.
  input  wire logic        guard,   // First dropped bit.
  input  wire logic        sticky,  // Or of the rest dropped.
  output logic      [24:0] sum,     // Rounded significand with carry.
  output logic             inexact  // Some dropped bit was set.
);

  logic inc; // Increment the kept significand.

  // Decides the increment from mode, sign and dropped bits.
  always_comb
  begin
    case (mode)
      rnd_nearest: inc = guard & (sticky | sig[0]);
      rnd_down:    inc = sign & (guard | sticky);
      rnd_up:      inc = ~sign & (guard | sticky);
      rnd_zero:    inc = 1'b0;
      default:     inc = 1'b0;
    endcase
    sum     = {1'b0, sig} + {24'h00_0000, inc};
    inexact = guard | sticky;
  end

endmodule // sxp_rounder

// ==== verilog/sxp_exc_post.sv ====
`timescale 1ns/10ps
module sxp_exc_post
  import sxp_pkg::*;
(
  input  wire logic        hclk,        // Bus and core clock.
  input  wire logic        hresetn,     // Asynchronous reset, active low.
  input  wire logic        hsel,        // Slave select.
  input  wire logic [31:0] haddr,       // Byte address.
  input  wire logic [1:0]  htrans,      // Transfer type.
  input  wire logic        hwrite,      // Write when high.
  input  wire logic [2:0]  hsize,       // Transfer size, word only.
  input  wire logic [31:0] hwdata,      // Write data.
  input  wire logic        hready,      // Bus ready.
  output logic             hreadyout,   // Slave ready.
  output logic             hresp,       // Response, always OKAY.
  output logic      [31:0] hrdata,      // Read data.
  input  wire logic        in_valid,    // Result from datapath valid.
  input  wire sxp_op_type  in_op,       // Operation that made it.
  input  wire logic        in_sign,     // Result sign.
  input  wire logic [9:0]  in_exp,      // Unbounded exponent, signed.
  input  wire logic [25:0] in_sig,      // Significand, guard, sticky.
  input  wire logic        in_zero,     // Exact zero result.
  input  wire logic [31:0] in_raw,      // Integer word of a conversion.
  input  wire logic        in_lost,     // Conversion dropped bits.
  output logic             out_valid,   // Delivered result valid.
  output logic      [31:0] out_result,  // Delivered result word.
  output logic             out_overflow_flag,  // Overflow status.
  output logic             out_underflow_flag, // Underflow status.
  output logic             out_inexact_flag,   // Inexact status.
  output logic             out_trap,    // Unmasked exception raised.
  output logic             irq          // Interrupt, level.
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  // True for the operations that can overflow or underflow.
  function automatic logic is_arith(input sxp_op_type op);
    is_arith = (op <= op_scalar_divide);
  endfunction
  // True for the conversions that deliver an integer word.
  function automatic logic is_to_int(input sxp_op_type op);
    is_to_int = (op >= op_packed_float_to_int);
  endfunction
  // Packs sign, unbiased exponent and significand into a word.
  function automatic logic [31:0] pack(input logic sign, input logic signed [10:0] exp,
                                       input logic [23:0] man);
    logic signed [10:0] bexp;
    bexp = exp + SXP_BIAS;
    pack = {sign, bexp[7:0], man[22:0]};
  endfunction
  // True when a register offset is hit by a bus address.
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ------------------------------------------------------------------
  // Registers and wires
  // ------------------------------------------------------------------
  logic        ovf_mask_ff, unf_mask_ff, inx_mask_ff; // Exception masks.
  sxp_rnd_type rnd_mode_ff;      // Rounding mode.
  logic [3:0]  status_ff, imask_ff; // Sticky event bits and interrupt enables.
  logic        wr_pend_ff;       // Write data phase pending.
  logic [31:0] wr_addr_ff;       // Address of that write.
  logic [31:0] hrdata_ff;        // Read data register.
  logic        hreadyout_ff, hresp_ff; // Ready and response registers.
  logic        out_valid_ff;     // Output valid register.
  logic [31:0] out_result_ff;    // Output result register.
  logic        out_ovf_ff, out_unf_ff, out_inx_ff; // Output flags.
  logic        out_trap_ff;      // Output trap register.
  logic        irq_ff;           // Interrupt register.

  logic        nxt_ovf_mask, nxt_unf_mask, nxt_inx_mask; // Masks after a pending write.
  sxp_rnd_type nxt_rnd_mode;     // Rounding mode after a pending write.
  logic [3:0]  nxt_imask, nxt_status; // Enables after a write; status after sets and clear.
  logic [31:0] nxt_rdata;        // Read data for this address.
  logic        addr_take, rd_status; // Address phase taken; status read taken.

  logic [24:0] sum_a, sum_b;     // Rounded unbounded and denormal significands.
  logic        inx_a, inx_b;     // Inexactness of those two roundings.
  logic signed [10:0] exp_r, sh_full; // Rounded exponent; denormal shift, unclamped.
  logic [23:0] man_r;            // Significand after rounding.
  logic [4:0]  sh;               // Denormal shift, clamped.
  logic [50:0] den;              // Denormalized significand.
  logic        huge, tiny;       // Rounded value above largest or below smallest normal.
  logic        sat_inf;          // Masked overflow gives infinity.
  logic [31:0] nxt_result;       // Result to deliver.
  logic        nxt_ovf, nxt_unf, nxt_inx, nxt_trap; // Flags and trap to raise.

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------

  assign addr_take = hsel & htrans[1] & hready;
  assign rd_status = addr_take & ~hwrite & hit(haddr, SXP_OFS_STATUS);

  // Control as it stands after a pending write, so a read right behind sees it.
  always_comb
  begin
    nxt_ovf_mask = ovf_mask_ff;
    nxt_unf_mask = unf_mask_ff;
    nxt_inx_mask = inx_mask_ff;
    nxt_rnd_mode = rnd_mode_ff;
    nxt_imask    = imask_ff;
    if (wr_pend_ff && hit(wr_addr_ff, SXP_OFS_CTRL))
    begin
      nxt_ovf_mask = hwdata[SXP_CTRL_OVF_MASK];
      nxt_unf_mask = hwdata[SXP_CTRL_UNF_MASK];
      nxt_inx_mask = hwdata[SXP_CTRL_INX_MASK];
      nxt_rnd_mode = sxp_rnd_type'(hwdata[SXP_CTRL_RND_LSB +: 2]);
    end
    if (wr_pend_ff && hit(wr_addr_ff, SXP_OFS_IMASK))
      nxt_imask = hwdata[3:0];
  end

  // Selects read data; unmapped addresses read as zero.
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (hit(haddr, SXP_OFS_CTRL))
    begin
      nxt_rdata[SXP_CTRL_OVF_MASK]      = nxt_ovf_mask;
      nxt_rdata[SXP_CTRL_UNF_MASK]      = nxt_unf_mask;
      nxt_rdata[SXP_CTRL_INX_MASK]      = nxt_inx_mask;
      nxt_rdata[SXP_CTRL_RND_LSB +: 2]  = nxt_rnd_mode;
    end
    else if (hit(haddr, SXP_OFS_STATUS))
      nxt_rdata[3:0] = status_ff;
    else if (hit(haddr, SXP_OFS_IMASK))
      nxt_rdata[3:0] = nxt_imask;
    else if (hit(haddr, SXP_OFS_RESULT))
      nxt_rdata = out_result_ff;
  end

  // Holds a write's address for its data phase and the bus answers;
  // every transfer is zero wait and OKAY, so ready and response stay put.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 32'h0000_0000;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      wr_pend_ff <= addr_take & hwrite;
      if (addr_take)
        wr_addr_ff <= haddr;
      if (addr_take && !hwrite)
        hrdata_ff <= nxt_rdata;
    end
  end

  // Stores masks, rounding mode and interrupt enables.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovf_mask_ff <= SXP_MASK_RST[SXP_CTRL_OVF_MASK];
      unf_mask_ff <= SXP_MASK_RST[SXP_CTRL_UNF_MASK];
      inx_mask_ff <= SXP_MASK_RST[SXP_CTRL_INX_MASK];
      rnd_mode_ff <= rnd_nearest;
      imask_ff    <= SXP_IMASK_RST;
    end
    else
    begin
      ovf_mask_ff <= nxt_ovf_mask;
      unf_mask_ff <= nxt_unf_mask;
      inx_mask_ff <= nxt_inx_mask;
      rnd_mode_ff <= nxt_rnd_mode;
      imask_ff    <= nxt_imask;
    end
  end

  // ------------------------------------------------------------------
  // Rounding and range detection
  // ------------------------------------------------------------------
  // Rounds the unbounded significand to destination precision.
  sxp_rounder u_round_unb (
    .sign    (in_sign),
    .mode    (rnd_mode_ff),
    .sig     (in_sig[25:2]),
    .guard   (in_sig[1]),
    .sticky  (in_sig[0]),
    .sum     (sum_a),
    .inexact (inx_a)
  );

  // Exponent and significand after rounding; a carry renormalizes.
  assign exp_r = {in_exp[9], in_exp} + {10'h000, sum_a[24]};
  assign man_r = sum_a[24] ? sum_a[24:1] : sum_a[23:0];

  // Range checks run on the rounded value, arithmetic ops only.
  assign huge = is_arith(in_op) & ~in_zero & (exp_r > SXP_EXP_MAX);
  assign tiny = is_arith(in_op) & ~in_zero & (exp_r < SXP_EXP_MIN);

  // Shift onto the denormal grid; the source sticky rides along, so one rounding suffices.
  assign sh_full = SXP_DEN_BASE - {in_exp[9], in_exp};
  assign sh = (sh_full < 11'sh000) ? 5'h00 :
              (sh_full > SXP_DEN_SHMAX) ? 5'h1F : sh_full[4:0];
  assign den = {in_sig, 25'h000_0000} >> sh;

  // Rounds the denormalized significand with bounded exponent.
  sxp_rounder u_round_den (
    .sign    (in_sign),
    .mode    (rnd_mode_ff),
    .sig     (den[50:27]),
    .guard   (den[26]),
    .sticky  (|den[25:0]),
    .sum     (sum_b),
    .inexact (inx_b)
  );

  // Masked overflow gives infinity in nearest mode or when rounding toward the sign.
  assign sat_inf = (rnd_mode_ff == rnd_nearest) | ((rnd_mode_ff == rnd_down) & in_sign) |
                   ((rnd_mode_ff == rnd_up) & ~in_sign);

  // ------------------------------------------------------------------
  // Response selection
  // ------------------------------------------------------------------
  // Chooses the delivered result, flags and trap for one result.
  always_comb
  begin
    nxt_result = pack(in_sign, exp_r, man_r);
    nxt_ovf    = 1'b0;
    nxt_unf    = 1'b0;
    nxt_inx    = inx_a;
    nxt_trap   = 1'b0;
    if (is_to_int(in_op))
    begin
      // Conversions to integer only report lost bits.
      nxt_result = in_raw;
      nxt_inx    = in_lost;
      nxt_trap   = in_lost & ~inx_mask_ff;
    end
    else if (in_zero)
    begin
      nxt_result = {in_sign, 31'h0000_0000};
      nxt_inx    = 1'b0;
    end
    else if (huge && !ovf_mask_ff)
    begin
      // Unmasked overflow outranks inexact and traps.
      nxt_result = pack(in_sign, exp_r - SXP_SCALE, man_r);
      nxt_ovf    = 1'b1;
      nxt_inx    = inx_a;
      nxt_trap   = 1'b1;
    end
    else if (huge)
    begin
      // Masked overflow saturates and is always inexact.
      nxt_result = {in_sign, sat_inf ? SXP_MAG_INF : SXP_MAG_MAX};
      nxt_ovf    = 1'b1;
      nxt_inx    = 1'b1;
      nxt_trap   = ~inx_mask_ff;
    end
    else if (tiny && !unf_mask_ff)
    begin
      // Unmasked underflow outranks inexact and traps.
      nxt_result = pack(in_sign, exp_r + SXP_SCALE, man_r);
      nxt_unf    = 1'b1;
      nxt_inx    = inx_a;
      nxt_trap   = 1'b1;
    end
    else if (tiny)
    begin
      // Masked underflow; a carry off the denormal grid lands in exponent one.
      nxt_result = {in_sign, {6'h00, sum_b}};
      nxt_unf    = inx_b;
      nxt_inx    = inx_b;
      nxt_trap   = inx_b & ~inx_mask_ff;
    end
    else
    begin
      // In range: bounded result, inexact as the rounding says.
      nxt_inx  = inx_a;
      nxt_trap = inx_a & ~inx_mask_ff;
    end
  end

  // Registers the delivered result and its flags, one per input.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_valid_ff  <= 1'b0;
      out_result_ff <= 32'h0000_0000;
      out_ovf_ff    <= 1'b0;
      out_unf_ff    <= 1'b0;
      out_inx_ff    <= 1'b0;
      out_trap_ff   <= 1'b0;
    end
    else
    begin
      out_valid_ff <= in_valid;
      if (in_valid)
      begin
        out_result_ff <= nxt_result;
        out_ovf_ff    <= nxt_ovf;
        out_unf_ff    <= nxt_unf;
        out_inx_ff    <= nxt_inx;
        out_trap_ff   <= nxt_trap;
      end
    end
  end

  // ------------------------------------------------------------------
  // Status and interrupt
  // ------------------------------------------------------------------
  // A read of status clears it; an event in the same cycle still sets.
  always_comb
  begin
    nxt_status = rd_status ? 4'h0 : status_ff;
    if (in_valid)
    begin
      nxt_status[SXP_ST_OVF]  = nxt_status[SXP_ST_OVF] | nxt_ovf;
      nxt_status[SXP_ST_UNF]  = nxt_status[SXP_ST_UNF] | nxt_unf;
      nxt_status[SXP_ST_INX]  = nxt_status[SXP_ST_INX] | nxt_inx;
      nxt_status[SXP_ST_TRAP] = nxt_status[SXP_ST_TRAP] | nxt_trap;
    end
  end

  // Holds sticky status and the interrupt level.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      status_ff <= 4'h0;
      irq_ff    <= 1'b0;
    end
    else
    begin
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & nxt_imask);
    end
  end

  // Every port comes straight from its register.
  assign hreadyout          = hreadyout_ff;
  assign hresp              = hresp_ff;
  assign hrdata             = hrdata_ff;
  assign out_valid          = out_valid_ff;
  assign out_result         = out_result_ff;
  assign out_overflow_flag  = out_ovf_ff;
  assign out_underflow_flag = out_unf_ff;
  assign out_inexact_flag   = out_inx_ff;
  assign out_trap           = out_trap_ff;
  assign irq                = irq_ff;

endmodule // sxp_exc_post

// ==== testbench/sxp_exc_post_properties.sv ====
`timescale 1ns/10ps
module sxp_exc_post_checker
  import sxp_pkg::*;
(
  input wire logic        hclk,               // Clock.
  input wire logic        hresetn,            // Reset, active low.
  input wire logic        in_valid,           // Input valid.
  input wire sxp_op_type  in_op,              // Operation.
  input wire logic        in_sign,            // Sign.
  input wire logic [9:0]  in_exp,             // Exponent.
  input wire logic [25:0] in_sig,             // Significand.
  input wire logic        in_zero,            // Zero.
  input wire logic        out_valid,          // Output valid.
  input wire logic [31:0] out_result,         // Result.
  input wire logic        out_overflow_flag,  // Overflow.
  input wire logic        out_underflow_flag, // Underflow.
  input wire logic        out_inexact_flag,   // Inexact.
  input wire logic        out_trap            // Trap.
);
  // ------
  // Result checks
  // ------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        easy; // Normal arithmetic input that needs no rounding.
  logic [31:0] word; // Word such an input must give.
  assign easy = in_valid && in_op < op_packed_square_root && !in_zero && in_sig[25]
             && in_sig[1:0] == 2'h0 && $signed(in_exp) > -127 && $signed(in_exp) < 128;
  assign word = {in_sign, 8'(in_exp + 10'd127), in_sig[24:2]};
  property p_lat; in_valid |=> out_valid; endproperty
  a_lat: assert property (p_lat) else $error("result missing");
  property p_idle; !in_valid |=> !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("result unasked");
  property p_ovf_sat; out_valid && out_overflow_flag && !out_trap |-> out_inexact_flag
    && (out_result[30:0] == SXP_MAG_INF || out_result[30:0] == SXP_MAG_MAX); endproperty
  a_ovf_sat: assert property (p_ovf_sat) else $error("bad saturation");
  property p_unf_pair; out_valid && out_underflow_flag && !out_trap |-> out_inexact_flag;
  endproperty
  a_unf_pair: assert property (p_unf_pair) else $error("lone underflow");
  property p_excl; out_valid |-> !(out_overflow_flag && out_underflow_flag); endproperty
  a_excl: assert property (p_excl) else $error("both range flags");
  property p_sqrt; in_valid && in_op >= op_packed_square_root
    && in_op <= op_scalar_int_to_float |=> !out_overflow_flag && !out_underflow_flag;
  endproperty
  a_sqrt: assert property (p_sqrt) else $error("range flag on sqrt");
  property p_notrap; out_valid && !out_overflow_flag && !out_underflow_flag
    && !out_inexact_flag |-> !out_trap; endproperty
  a_notrap: assert property (p_notrap) else $error("trap without cause");
  property p_exact; easy |=> out_result == $past(word) && !out_inexact_flag && !out_trap;
  endproperty
  a_exact: assert property (p_exact) else $error("exact result wrong");
  c_ovf: cover property (out_valid && out_overflow_flag && out_trap);
  c_unf: cover property (out_valid && out_underflow_flag && out_inexact_flag);
  c_inx: cover property (out_valid && out_inexact_flag && out_trap);
endmodule // sxp_exc_post_checker

bind sxp_exc_post sxp_exc_post_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .in_valid(in_valid), .in_op(in_op), .in_sign(in_sign), .in_exp(in_exp), .in_sig(in_sig),
  .in_zero(in_zero), .out_valid(out_valid), .out_result(out_result),
  .out_overflow_flag(out_overflow_flag), .out_underflow_flag(out_underflow_flag),
  .out_inexact_flag(out_inexact_flag), .out_trap(out_trap));

// ==== testbench/sxp_datapath_model.sv ====
`timescale 1ns/10ps
module sxp_datapath_model
  import sxp_pkg::*;
(
  input  wire logic   hclk,     // Core clock.
  output logic        in_valid, // Result valid pulse.
  output sxp_op_type  in_op,    // Operation code.
  output logic        in_sign,  // Sign.
  output logic [9:0]  in_exp,   // Unbounded exponent.
  output logic [25:0] in_sig,   // Significand, guard, sticky.
  output logic        in_zero,  // Exact zero.
  output logic [31:0] in_raw,   // Integer word.
  output logic        in_lost   // Conversion lost bits.
);
  // Idle values at time zero.
  initial
  begin
    {in_valid, in_sign, in_exp, in_sig, in_zero, in_raw, in_lost} = '0;
    in_op = op_packed_add;
  end
  // Sends one result; afterwards all data lines but in_op and in_zero show the inverse, not stale values.
  task automatic send(input sxp_op_type o, input logic s, input logic [9:0] e,
                      input logic [25:0] g, input logic [31:0] r, input logic l);
    @(posedge hclk);
    {in_valid, in_op, in_sign, in_exp, in_sig, in_raw, in_lost} <= {1'b1, o, s, e, g, r, l};
    @(posedge hclk);
    {in_valid, in_sign, in_exp, in_sig, in_raw, in_lost} <= {1'b0, ~s, ~e, ~g, ~r, ~l};
  endtask
endmodule // sxp_datapath_model

// ==== testbench/sxp_exc_post_bench.sv ====
`timescale 1ns/10ps
module sxp_exc_post_bench;
  import sxp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq; // Bus side.
  logic [1:0]  htrans;                              // Transfer type.
  logic [2:0]  hsize;                               // Transfer size.
  logic [31:0] haddr, hwdata, hrdata, in_raw, out_result, v, c, r; // Words.
  logic        in_valid, in_sign, in_zero, in_lost, out_valid, out_trap, s; // Result path.
  logic        out_overflow_flag, out_underflow_flag, out_inexact_flag; // Flags.
  logic [9:0]  in_exp, e;                           // Exponents.
  logic [25:0] in_sig, g;                           // Significands.
  sxp_op_type  in_op, o;                            // Operations.
  int          bad_count, total_checks, cyc;        // Counters.
  always #4 hclk = ~hclk; // 125 MHz.
  sxp_exc_post u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid),
    .in_op(in_op), .in_sign(in_sign), .in_exp(in_exp), .in_sig(in_sig), .in_zero(in_zero),
    .in_raw(in_raw), .in_lost(in_lost), .out_valid(out_valid), .out_result(out_result),
    .out_overflow_flag(out_overflow_flag), .out_underflow_flag(out_underflow_flag),
    .out_inexact_flag(out_inexact_flag), .out_trap(out_trap), .irq(irq));
  sxp_datapath_model u_dp (.hclk(hclk), .in_valid(in_valid), .in_op(in_op),
    .in_sign(in_sign), .in_exp(in_exp), .in_sig(in_sig), .in_zero(in_zero),
    .in_raw(in_raw), .in_lost(in_lost));
  // ------
  // Tasks
  // ------
  // One single word transfer; waits for ready in both phases.
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (!hreadyout);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (!hreadyout);
    q = hrdata;
  endtask
  task automatic chk_word(input logic [31:0] got, x);
    total_checks++;
    if (got !== x)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, x);
    end
  endtask
  task automatic chk_flags(input logic [3:0] got, x);
    chk_word({28'h0, got}, {28'h0, x});
  endtask
  task automatic rchk(input logic [31:0] a, x);
    ahb(1'b0, a, 32'h0, v);
    chk_word(v, x);
    chk_flags({3'h0, hresp}, 4'h0);
  endtask
  // Sends a result, then checks word and flags {ovf, unf, inx, trap} one cycle on.
  task automatic run(input sxp_op_type ot, input logic ss, input logic [9:0] ee,
                     input logic [25:0] gg, input logic [31:0] xr, input logic [3:0] xf);
    u_dp.send(ot, ss, ee, gg, r, in_lost_pick(ot));
    #1;
    chk_word(out_result, xr);
    chk_flags({out_overflow_flag, out_underflow_flag, out_inexact_flag, out_trap}, xf);
    chk_flags({3'h0, out_valid}, 4'h1);
  endtask
  function automatic logic in_lost_pick(input sxp_op_type ot);
    return ot >= op_packed_float_to_int && c[7];
  endfunction
  // Saturated word: infinity unless rounding points away from the result's sign.
  function automatic logic [31:0] sat_word(input logic ss, input logic [1:0] m);
    return {ss, (m == 2'h0 || (m == 2'h1 && ss) || (m == 2'h2 && !ss)) ? SXP_MAG_INF
                                                                        : SXP_MAG_MAX};
  endfunction
  function automatic logic [31:0] norm(input logic ss, input logic [9:0] ee, b,
                                       input logic [22:0] f);
    return {ss, 8'(ee + b), f};
  endfunction
  task automatic final_report;
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end
  // ------
  // Main sequence
  // ------
  initial
  begin
    {hclk, hresetn, hsel, haddr, htrans, hwrite, hwdata, c, r} = '0;
    hsize = 3'h2;
    void'($urandom(15));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(SXP_OFS_CTRL, 32'h7);
    rchk(SXP_OFS_IMASK, 32'h0);
    ahb(1'b1, 32'h10, 32'hF, v);
    rchk(32'h10, 32'h0);
    rchk(SXP_OFS_STATUS, 32'h0);
    for (int m = 0; m < 8; m++)
    begin
      ahb(1'b1, SXP_OFS_CTRL, {27'h0, 2'(m / 2), 3'h7}, v);
      run(op_scalar_multiply, 1'(m), 10'd200, '1, sat_word(1'(m), 2'(m / 2)), 4'hA);
    end
    ahb(1'b1, SXP_OFS_CTRL, 32'h6, v);
    run(op_packed_add, 1'b1, 10'd150, {24'h812345, 2'h0},
        norm(1'b1, 10'd150, 10'h3BF, 23'h012345), 4'h9);
    run(op_packed_add, 1'b0, 10'd150, {24'h812345, 2'h3},
        norm(1'b0, 10'd150, 10'h3BF, 23'h012346), 4'hB);
    ahb(1'b1, SXP_OFS_CTRL, 32'h5, v);
    run(op_scalar_divide, 1'b0, 10'h36A, {24'h812345, 2'h0},
        norm(1'b0, 10'h36A, 10'h13F, 23'h012345), 4'h5);
    for (int k = 0; k < 8; k += 4)
    begin
      ahb(1'b1, SXP_OFS_CTRL, 32'h7 - k, v);
      run(op_packed_multiply, 1'b0, 10'h37E, {24'h800000, 2'h0}, 32'h00080000, 4'h0);
      run(op_packed_multiply, 1'b0, 10'h37E, {24'h800001, 2'h0}, 32'h00080000,
          4'h6 | 4'(k / 4));
      run(op_scalar_add, 1'b0, 10'h0, {24'h800000, 2'h3}, 32'h3F800001,
          4'h2 | 4'(k / 4));
    end
    run(op_scalar_multiply, 1'b0, 10'd200, '1, 32'h7F800000, 4'hB);
    ahb(1'b1, SXP_OFS_CTRL, 32'h0, v);
    run(op_packed_add, 1'b0, 10'd150, {24'h812345, 2'h3},
        norm(1'b0, 10'd150, 10'h3BF, 23'h012346), 4'hB);
    rchk(SXP_OFS_STATUS, 32'hF);
    ahb(1'b1, SXP_OFS_CTRL, 32'h7, v);
    run(op_scalar_add, 1'b0, 10'h0, {24'h800000, 2'h3}, 32'h3F800001, 4'h2);
    chk_flags({3'h0, irq}, 4'h0);
    ahb(1'b1, SXP_OFS_IMASK, 32'h4, v);
    @(posedge hclk);
    #1;
    chk_flags({3'h0, irq}, 4'h1);
    rchk(SXP_OFS_STATUS, 32'h4);
    repeat (2) @(posedge hclk);
    #1;
    chk_flags({3'h0, irq}, 4'h0);
    rchk(SXP_OFS_RESULT, 32'h3F800001);
    repeat (150)
    begin
      {c, r, s} = {$urandom, $urandom, 1'($urandom)};
      o = sxp_op_type'($urandom_range(15));
      e = 10'($urandom_range(253)) - 10'd126;
      g = {1'b1, 23'($urandom), 2'h0};
      ahb(1'b1, SXP_OFS_CTRL, {27'h0, c[4:0]}, v);
      if (o >= op_packed_float_to_int)
        run(o, s, e, g, r, {2'h0, c[7], c[7] & ~c[2]});
      else
        run(o, s, e, g, norm(s, e, 10'd127, g[24:2]), 4'h0);
    end
    final_report();
  end
endmodule // sxp_exc_post_bench
